// File: rtl/esr_defs.svh
// Constants of the serial EEPROM read and addressing front end.
// Assumes inclusion by bare name from the package, the read buffer and the top module.
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH
`define ESR_CLK_MHZ 25
`define ESR_ADDR_W 14
`define ESR_TMR_W 22
`define ESR_SYNC_STAGES 3
`define ESR_FIFO_DEPTH 2
`define ESR_POR_TIME_US 100000
`define ESR_WRITE_TIME_US 10000
// Arbitrary neutral device type identifier
`define ESR_TYPE_ID_DEFAULT 4'h6
`define ESR_CTRL_SEL_BIT 7
`define ESR_CMD_CLR_WEL 8'h00
`define ESR_CMD_SET_WEL 8'h02
`define ESR_CMD_SET_REGISTER_WRITE_LATCH 8'h06
`define ESR_CTRL_PROTECT_PIN_ENABLE_BIT 7
`define ESR_CTRL_WD_HI 6
`define ESR_CTRL_WD_LO 5
`define ESR_CTRL_BP2_BIT 4
`define ESR_CTRL_BP1_BIT 3
`define ESR_CTRL_KEEP_BIT 2
`define ESR_CTRL_ONE_BIT 1
`define ESR_CTRL_BP0_BIT 0
`endif

// File: rtl/esr_fifo2.sv
// Two-entry read-ahead buffer with valid/ready on both sides.
// Assumes a synchronous flush that wins over a push in the same cycle.
`timescale 1ns/10ps
`include "esr_defs.svh"
module esr_fifo2 import esr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  esr_stream_if.dst push_if,
  esr_stream_if.src pop_if
);
  localparam logic [1:0] DEPTH = 2'(`ESR_FIFO_DEPTH);
  esr_byte_t data_r [0:`ESR_FIFO_DEPTH-1];
  esr_byte_t data_nxt [0:`ESR_FIFO_DEPTH-1];
  logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [1:0] count_r, count_nxt;
  logic do_push, do_pop;

  // Honest full and empty straight from the fill count
  assign push_if.ready = (count_r != DEPTH);
  assign pop_if.valid = (count_r != 2'h0);
  assign pop_if.data = data_r[rd_ptr_r];

  // Next pointers, count and storage
  always_comb
  begin
    do_push = push_if.valid & push_if.ready;
    do_pop = pop_if.valid & pop_if.ready;
    data_nxt = data_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (flush_in)
    begin
      wr_ptr_nxt = 1'h0;
      rd_ptr_nxt = 1'h0;
      count_nxt = 2'h0;
    end
    else
    begin
      if (do_push)
      begin
        data_nxt[wr_ptr_r] = push_if.data;
        wr_ptr_nxt = ~wr_ptr_r;
      end
      if (do_pop)
        rd_ptr_nxt = ~rd_ptr_r;
      count_nxt = count_r + {1'h0, do_push} - {1'h0, do_pop};
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_r <= 1'h0;
      rd_ptr_r <= 1'h0;
      count_r <= 2'h0;
      data_r <= '{default: 8'h00};
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      data_r <= data_nxt;
    end
  end
endmodule // esr_fifo2

// File: rtl/esr_pkg.sv
// Types shared by the serial EEPROM front end.
// Assumes esr_defs.svh is on the include path.
`include "esr_defs.svh"
package esr_pkg;
  typedef logic [7:0] esr_byte_t;
  typedef logic [`ESR_ADDR_W-1:0] esr_addr_t;
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_RLOAD,
    ST_TX,
    ST_RACK,
    ST_WAIT_STOP
  } esr_state_e;
endpackage

// File: rtl/esr_stream_if.sv
// Valid/ready byte stream between the top and its read buffer.
// Assumes one clock domain on both ends.
`timescale 1ns/10ps
interface esr_stream_if import esr_pkg::*;;
  esr_byte_t data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport dst(input data, input valid, output ready);
endinterface // esr_stream_if

// File: rtl/esr_top.sv
// Two-wire slave front end of a supervisor EEPROM: reads, addressing,
// power-up reset timing and write protection gating.
// Assumes SCL, SDA, WP and the select straps arrive asynchronously.
`timescale 1ns/10ps
`include "esr_defs.svh"
module esr_top import esr_pkg::*;
#(
  parameter int POR_TIME_US = `ESR_POR_TIME_US,
  parameter int WRITE_TIME_US = `ESR_WRITE_TIME_US,
  parameter logic [3:0] DEVICE_TYPE_ID = `ESR_TYPE_ID_DEFAULT // arbitrary value
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  input wire logic chip_select_hi_in,
  input wire logic chip_select_lo_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic reset_active_out,
  output logic write_busy_out,
  output logic write_enable_latch_out,
  output logic register_write_latch_out,
  output logic protect_pin_enable_out,
  output logic [1:0] watchdog_sel_out,
  output logic [2:0] region_lock_out
);
  localparam int NPIN = 5;
  localparam int P_SCL = 4;
  localparam int P_SDA = 3;
  localparam int P_WP = 2;
  localparam int P_CSH = 1;
  localparam int P_CSL = 0;
  localparam int TW = `ESR_TMR_W;
  localparam int POR_CYCLES = POR_TIME_US * `ESR_CLK_MHZ;
  localparam int WRITE_CYCLES = WRITE_TIME_US * `ESR_CLK_MHZ;
  localparam logic [TW-1:0] POR_LAST = TW'(POR_CYCLES - 1);
  localparam logic [TW-1:0] WR_LAST = TW'(WRITE_CYCLES - 1);

  // Region lock decode, upper parts of the array
  function automatic logic lock_hit(input logic [2:0] bp, input esr_addr_t a);
    unique case (bp)
      3'h0: lock_hit = 1'h0;
      3'h1: lock_hit = &a[13:12];
      3'h2: lock_hit = a[13];
      3'h3: lock_hit = 1'h1;
      3'h4: lock_hit = &a[13:6];
      3'h5: lock_hit = &a[13:7];
      3'h6: lock_hit = &a[13:8];
      3'h7: lock_hit = &a[13:9];
    endcase
  endfunction

  logic [NPIN-1:0] pins, s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic scl_rise, scl_fall, sda_bit, start_ev, stop_ev;
  esr_state_e state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  esr_byte_t shreg_r, shreg_nxt, addr_hi_r, addr_hi_nxt, wdata_r, wdata_nxt;
  logic [1:0] widx_r, widx_nxt, wd_r, wd_nxt;
  logic [2:0] bp_r, bp_nxt;
  esr_addr_t addr_cnt_r, addr_cnt_nxt, fetch_addr_r, fetch_addr_nxt;
  logic rw_r, rw_nxt, ctrl_sel_r, ctrl_sel_nxt, wvalid_r, wvalid_nxt;
  logic ack_r, ack_nxt, sda_oe_r, sda_oe_nxt, sda_low_r;
  logic wel_r, wel_nxt, register_write_latch_r, register_write_latch_nxt, protect_pin_enable_r, protect_pin_enable_nxt;
  logic wr_start, mem_we, fifo_flush, inhibit, slave_match, byte_ok;
  logic [TW-1:0] por_cnt_r, por_cnt_nxt, busy_cnt_r, busy_cnt_nxt;
  logic por_active_r, por_active_nxt, busy_r, busy_nxt;
  esr_byte_t mem_r [0:(1 << `ESR_ADDR_W)-1];

  esr_stream_if push_if();
  esr_stream_if pop_if();

  // Read-ahead buffer between the array and the shifter
  esr_fifo2 u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .push_if(push_if.dst),
    .pop_if(pop_if.src)
  );

  // Pin filters: a level moves only when the last two stages agree
  assign pins = {scl_in, sda_in, wp_in, chip_select_hi_in, chip_select_lo_in};
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    always_comb
    begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1_r <= {NPIN{1'h1}};
      s2_r <= {NPIN{1'h1}};
      s3_r <= {NPIN{1'h1}};
      lvl_r <= {NPIN{1'h1}}; // WP seen high, which blocks nothing while protect_pin_enable_r is clear
    end
    else
    begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Bus events from filtered levels
  assign scl_rise = lvl_nxt[P_SCL] & ~lvl_r[P_SCL];
  assign scl_fall = ~lvl_nxt[P_SCL] & lvl_r[P_SCL];
  assign sda_bit = lvl_r[P_SDA];
  assign start_ev = lvl_r[P_SCL] & lvl_nxt[P_SCL] & lvl_r[P_SDA] & ~lvl_nxt[P_SDA];
  assign stop_ev = lvl_r[P_SCL] & lvl_nxt[P_SCL] & ~lvl_r[P_SDA] & lvl_nxt[P_SDA];
  assign inhibit = por_active_r | busy_r;
  assign slave_match = (shreg_r[7:1] == {DEVICE_TYPE_ID, 1'h0, lvl_r[P_CSH], lvl_r[P_CSL]});

  // Array prefetch; a flush wins over the push in its cycle
  assign push_if.data = mem_r[fetch_addr_r];
  assign push_if.valid = ~fifo_flush;

  // Protocol engine, latches and address counter
  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shreg_nxt = shreg_r;
    rw_nxt = rw_r;
    widx_nxt = widx_r;
    addr_hi_nxt = addr_hi_r;
    addr_cnt_nxt = addr_cnt_r;
    ctrl_sel_nxt = ctrl_sel_r;
    wdata_nxt = wdata_r;
    wvalid_nxt = wvalid_r;
    ack_nxt = ack_r;
    sda_oe_nxt = sda_oe_r;
    wel_nxt = wel_r;
    register_write_latch_nxt = register_write_latch_r;
    protect_pin_enable_nxt = protect_pin_enable_r;
    wd_nxt = wd_r;
    bp_nxt = bp_r;
    wr_start = 1'h0;
    mem_we = 1'h0;
    fifo_flush = 1'h0;
    pop_if.ready = 1'h0;
    byte_ok = 1'h0;
    if (inhibit)
    begin
      // Transfers dropped, line released while reset or write cycle runs
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'h0;
      wvalid_nxt = 1'h0;
    end
    else if (stop_ev)
    begin
      if (wvalid_r)
      begin
        if (ctrl_sel_r)
        begin
          if (wdata_r == `ESR_CMD_CLR_WEL)
            wel_nxt = 1'h0;
          else if (wdata_r == `ESR_CMD_SET_WEL)
            wel_nxt = 1'h1;
          else if (wdata_r == `ESR_CMD_SET_REGISTER_WRITE_LATCH)
          begin
            if (wel_r)
            begin
              register_write_latch_nxt = 1'h1;
              wel_nxt = 1'h1;
            end
          end
          else if (wel_r && register_write_latch_r && wdata_r[`ESR_CTRL_ONE_BIT])
          begin
            protect_pin_enable_nxt = wdata_r[`ESR_CTRL_PROTECT_PIN_ENABLE_BIT];
            wd_nxt = {wdata_r[`ESR_CTRL_WD_HI], wdata_r[`ESR_CTRL_WD_LO]};
            bp_nxt = {wdata_r[`ESR_CTRL_BP2_BIT], wdata_r[`ESR_CTRL_BP1_BIT],
                      wdata_r[`ESR_CTRL_BP0_BIT]};
            register_write_latch_nxt = wdata_r[`ESR_CTRL_KEEP_BIT];
            wr_start = 1'h1;
          end
        end
        else
        begin
          mem_we = 1'h1;
          wr_start = 1'h1;
          addr_cnt_nxt = addr_cnt_r + 14'h1;
        end
      end
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'h0;
      wvalid_nxt = 1'h0;
    end
    else if (start_ev)
    begin
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      sda_oe_nxt = 1'h0;
      wvalid_nxt = 1'h0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE, ST_WAIT_STOP:
        begin
          sda_oe_nxt = 1'h0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shreg_nxt = {shreg_r[6:0], sda_bit};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            if (slave_match)
            begin
              sda_oe_nxt = 1'h1;
              rw_nxt = shreg_r[0];
              fifo_flush = shreg_r[0];
              state_nxt = ST_ACK_ADDR;
            end
            else
              state_nxt = ST_IDLE;
          end
        end
        ST_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            sda_oe_nxt = 1'h0;
            bit_cnt_nxt = 4'h0;
            widx_nxt = 2'h0;
            state_nxt = rw_r ? ST_RLOAD : ST_RX;
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            shreg_nxt = {shreg_r[6:0], sda_bit};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            unique case (widx_r)
              2'h0:
              begin
                addr_hi_nxt = shreg_r;
                byte_ok = 1'h1;
              end
              2'h1:
              begin
                addr_cnt_nxt = {addr_hi_r[5:0], shreg_r};
                ctrl_sel_nxt = addr_hi_r[`ESR_CTRL_SEL_BIT];
                byte_ok = 1'h1;
              end
              2'h2:
              begin
                if (ctrl_sel_r)
                  byte_ok = ~(lvl_r[P_WP] & protect_pin_enable_r);
                else
                begin
                  byte_ok = wel_r & ~lock_hit(bp_r, addr_cnt_r);
                  if (lock_hit(bp_r, addr_cnt_r))
                    register_write_latch_nxt = 1'h0;
                end
                wdata_nxt = shreg_r;
              end
              2'h3:
              begin
                byte_ok = 1'h0; // Only single-byte writes are held
              end
            endcase
            if (widx_r != 2'h3)
              widx_nxt = widx_r + 2'h1;
            ack_nxt = byte_ok;
            sda_oe_nxt = byte_ok;
            state_nxt = ST_ACK_RX;
          end
          // A stop shows one SCL rise first, so only a whole bit cancels
          else if (scl_fall)
            wvalid_nxt = 1'h0;
        end
        ST_ACK_RX:
        begin
          if (scl_fall)
          begin
            sda_oe_nxt = 1'h0;
            bit_cnt_nxt = 4'h0;
            wvalid_nxt = ack_r & (widx_r == 2'h3);
            state_nxt = ack_r ? ST_RX : ST_WAIT_STOP;
          end
        end
        ST_RLOAD:
        begin
          // Stalls on an empty buffer; SCL low time hides the wait
          pop_if.ready = 1'h1;
          if (pop_if.valid)
          begin
            shreg_nxt = pop_if.data;
            sda_oe_nxt = ~pop_if.data[7];
            bit_cnt_nxt = 4'h1;
            addr_cnt_nxt = addr_cnt_r + 14'h1;
            state_nxt = ST_TX;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              sda_oe_nxt = 1'h0;
              state_nxt = ST_RACK;
            end
            else
            begin
              sda_oe_nxt = ~shreg_r[6];
              shreg_nxt = {shreg_r[6:0], 1'h0};
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            shreg_nxt = {7'h00, ~sda_bit};
          else if (scl_fall)
            state_nxt = shreg_r[0] ? ST_RLOAD : ST_WAIT_STOP;
        end
      endcase
    end
    // Prefetch restarts at the counter on each read address match
    if (fifo_flush)
      fetch_addr_nxt = addr_cnt_r;
    else if (push_if.ready)
      fetch_addr_nxt = fetch_addr_r + 14'h1;
    else
      fetch_addr_nxt = fetch_addr_r;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      rw_r <= 1'h0;
      widx_r <= 2'h0;
      addr_hi_r <= 8'h00;
      addr_cnt_r <= 14'h0000;
      fetch_addr_r <= 14'h0000;
      ctrl_sel_r <= 1'h0;
      wdata_r <= 8'h00;
      wvalid_r <= 1'h0;
      ack_r <= 1'h0;
      sda_oe_r <= 1'h0;
      sda_low_r <= 1'h0;
      wel_r <= 1'h0;
      register_write_latch_r <= 1'h0;
      protect_pin_enable_r <= 1'h0;
      wd_r <= 2'h0;
      bp_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shreg_r <= shreg_nxt;
      rw_r <= rw_nxt;
      widx_r <= widx_nxt;
      addr_hi_r <= addr_hi_nxt;
      addr_cnt_r <= addr_cnt_nxt;
      fetch_addr_r <= fetch_addr_nxt;
      ctrl_sel_r <= ctrl_sel_nxt;
      wdata_r <= wdata_nxt;
      wvalid_r <= wvalid_nxt;
      ack_r <= ack_nxt;
      sda_oe_r <= sda_oe_nxt;
      sda_low_r <= 1'h0; // Open drain: only ever pulls low
      wel_r <= wel_nxt;
      register_write_latch_r <= register_write_latch_nxt;
      protect_pin_enable_r <= protect_pin_enable_nxt;
      wd_r <= wd_nxt;
      bp_r <= bp_nxt;
    end
  end

  // Array storage, contents undefined until written
  always_ff @(posedge clk_sys_in)
  begin
    if (mem_we)
      mem_r[addr_cnt_r] <= wdata_r;
  end

  // Power-on reset hold and write cycle timers
  always_comb
  begin
    por_cnt_nxt = por_cnt_r;
    por_active_nxt = por_active_r;
    busy_cnt_nxt = busy_cnt_r;
    busy_nxt = busy_r;
    if (por_active_r)
    begin
      if (por_cnt_r == POR_LAST)
        por_active_nxt = 1'h0;
      else
        por_cnt_nxt = por_cnt_r + {{(TW-1){1'h0}}, 1'h1};
    end
    if (wr_start)
    begin
      busy_nxt = 1'h1;
      busy_cnt_nxt = {TW{1'h0}};
    end
    else if (busy_r)
    begin
      if (busy_cnt_r == WR_LAST)
        busy_nxt = 1'h0;
      else
        busy_cnt_nxt = busy_cnt_r + {{(TW-1){1'h0}}, 1'h1};
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      por_cnt_r <= {TW{1'h0}};
      por_active_r <= 1'h1;
      busy_cnt_r <= {TW{1'h0}};
      busy_r <= 1'h0;
    end
    else
    begin
      por_cnt_r <= por_cnt_nxt;
      por_active_r <= por_active_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Outputs, all straight from flops
  assign sda_out = sda_low_r;
  assign sda_oe_out = sda_oe_r;
  assign reset_active_out = por_active_r;
  assign write_busy_out = busy_r;
  assign write_enable_latch_out = wel_r;
  assign register_write_latch_out = register_write_latch_r;
  assign protect_pin_enable_out = protect_pin_enable_r;
  assign watchdog_sel_out = wd_r;
  assign region_lock_out = bp_r;
endmodule // esr_top

// File: verification/esr_master.sv
// Two-wire bus master model driving SCL and the data wire.
// Assumes a pulled-up data wire; the device only pulls it low.
`timescale 1ns/10ps
module esr_master import esr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic drv_low = 1'b0;
  initial scl_out = 1'b1;
  // Wired-AND with pull-up, so a released line reads high
  assign sda_out = ~(drv_low | sda_oe_in);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // 5 low, 3 high: leaves room for the device's filter delay
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    drv_low = ~b;
    tick(4);
    scl_out = 1'b1;
    tick(3);
    r = sda_out;
    scl_out = 1'b0;
  endtask
  // Waits for a device acknowledge to be let go before raising SCL
  task automatic start();
    drv_low = 1'b0;
    tick(5);
    scl_out = 1'b1;
    tick(3);
    drv_low = 1'b1;
    tick(3);
    scl_out = 1'b0;
  endtask
  // Clock stays high afterwards: bus idle between frames
  task automatic stop();
    tick(1);
    drv_low = 1'b1;
    tick(3);
    scl_out = 1'b1;
    tick(3);
    drv_low = 1'b0;
    tick(4);
  endtask
  task automatic wbits(input esr_byte_t b, input int n, output logic ack);
    logic r;
    for (int i = 7; i > 7 - n; i--)
      bit_io(b[i], r);
    if (n == 8)
      bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic mack, output esr_byte_t d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~mack, r);
  endtask
endmodule // esr_master

// File: verification/esr_props.sv
// Port-level checks on the serial EEPROM front end.
// Assumes it is bound into esr_top and sees only its ports.
`timescale 1ns/10ps
module esr_props import esr_pkg::*;
#(
  parameter int POR_TIME_US = 2,
  parameter int WRITE_TIME_US = 2
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic reset_active_out,
  input wire logic write_busy_out,
  input wire logic write_enable_latch_out,
  input wire logic register_write_latch_out,
  input wire logic [2:0] region_lock_out
);
  localparam int POR_CYC = POR_TIME_US * 25;
  localparam int WR_CYC = WRITE_TIME_US * 25;
  int por_cnt_r;
  int por_cnt_nxt;
  int wr_cnt_r;
  int wr_cnt_nxt;
  default clocking dflt @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Length counters; one cycle of slack covers the registered outputs
  always_comb
  begin
    por_cnt_nxt = reset_active_out ? por_cnt_r + 1 : 0;
    wr_cnt_nxt = write_busy_out ? wr_cnt_r + 1 : 0;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      por_cnt_r <= 0;
      wr_cnt_r <= 0;
    end
    else
    begin
      por_cnt_r <= por_cnt_nxt;
      wr_cnt_r <= wr_cnt_nxt;
    end
  end
  a_por_held: assert property ($rose(reset_n_in) |-> reset_active_out [*8])
    else $error("reset output dropped early");
  a_por_length: assert property ($fell(reset_active_out) |-> por_cnt_r >= POR_CYC - 1 && por_cnt_r <= POR_CYC + 1)
    else $error("reset output length wrong");
  a_latch_cleared: assert property ($rose(reset_n_in) |-> !write_enable_latch_out && !register_write_latch_out && region_lock_out == 3'h0)
    else $error("latches not clear after reset");
  a_reset_quiet: assert property (reset_active_out |-> !sda_oe_out)
    else $error("bus driven during reset");
  a_drive_low: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data pin driven high");
  a_commit_needs_wel: assert property ($rose(write_busy_out) |-> $past(write_enable_latch_out))
    else $error("write cycle without latch");
  a_busy_length: assert property ($fell(write_busy_out) |-> wr_cnt_r >= WR_CYC - 1 && wr_cnt_r <= WR_CYC + 1)
    else $error("write cycle length wrong");
  a_busy_quiet: assert property (write_busy_out |-> !sda_oe_out)
    else $error("bus driven during write cycle");
  a_unlock_needs_wel: assert property ($rose(register_write_latch_out) |-> $past(write_enable_latch_out))
    else $error("register latch set without write latch");
  a_lock_needs_unlock: assert property ($changed(region_lock_out) |-> $past(register_write_latch_out))
    else $error("lock bits changed while locked");
endmodule // esr_props

bind esr_top esr_props #(.POR_TIME_US(POR_TIME_US), .WRITE_TIME_US(WRITE_TIME_US)) i_props (
  .clk_sys_in(clk_sys_in),
  .reset_n_in(reset_n_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .reset_active_out(reset_active_out),
  .write_busy_out(write_busy_out),
  .write_enable_latch_out(write_enable_latch_out),
  .register_write_latch_out(register_write_latch_out),
  .region_lock_out(region_lock_out)
);

// File: verification/esr_top_tb.sv
// Self-checking bench for the EEPROM front end.
// Assumes esr_master drives the bus; checker bound separately.
`timescale 1ns/10ps
module esr_top_tb import esr_pkg::*;;
  localparam logic [3:0] TYPE_ID = 4'h6; // arbitrary value
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic scl, sda, sda_o, sda_oe, rst_act, busy, write_enable_latch, register_write_latch, protect_pin_enable, ack;
  logic wp = 1'b0, cs_hi = 1'b1, cs_lo = 1'b0;
  logic [1:0] wd;
  logic [2:0] lock;
  esr_byte_t rd;
  int mismatches = 0;
  int n_compared = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  esr_top #(.POR_TIME_US(2), .WRITE_TIME_US(2), .DEVICE_TYPE_ID(TYPE_ID)) i_dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
    .wp_in(wp), .chip_select_hi_in(cs_hi), .chip_select_lo_in(cs_lo),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .reset_active_out(rst_act),
    .write_busy_out(busy), .write_enable_latch_out(write_enable_latch), .register_write_latch_out(register_write_latch),
    .protect_pin_enable_out(protect_pin_enable), .watchdog_sel_out(wd), .region_lock_out(lock));
  esr_master i_mst (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp8(input esr_byte_t got, input esr_byte_t exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  // Bounded wait for reset and write cycle to end
  task automatic wait_clear();
    int n = 0;
    while ((busy !== 1'b0 || rst_act !== 1'b0) && n < 500)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 500)
    begin
      mismatches++;
      summarize();
    end
    i_mst.tick(4);
  endtask
  task automatic sel(input logic rw, output logic a);
    i_mst.start();
    i_mst.wbits({TYPE_ID, 1'b0, cs_hi, cs_lo, rw}, 8, a);
  endtask
  // Single write; busy shortly after stop tells whether it committed
  task automatic wr(input esr_byte_t hi, input esr_byte_t lo, input esr_byte_t d,
                    input logic exp_ack, input logic exp_busy);
    sel(1'b0, ack);
    i_mst.wbits(hi, 8, ack);
    i_mst.wbits(lo, 8, ack);
    i_mst.wbits(d, 8, ack);
    cmp1(ack, exp_ack);
    i_mst.stop();
    i_mst.tick(8);
    cmp1(busy, exp_busy);
    wait_clear();
  endtask
  task automatic t_power_up();
    cmp1(rst_act, 1'b1);
    cmp1(sda_oe, 1'b0);
    cmp1(sda_o, 1'b0);
    sel(1'b1, ack);
    cmp1(ack, 1'b0);
    i_mst.stop();
    wait_clear();
    cmp1(write_enable_latch, 1'b0);
  endtask
  task automatic t_select();
    esr_byte_t bad[2] = '{{TYPE_ID, 4'h3}, {TYPE_ID, 4'hD}};
    foreach (bad[i])
    begin
      i_mst.start();
      i_mst.wbits(bad[i], 8, ack);
      cmp1(ack, 1'b0);
      i_mst.stop();
    end
    // Straps are compared live: a moved strap moves the address
    cs_lo = 1'b1;
    sel(1'b0, ack);
    cmp1(ack, 1'b1);
    i_mst.stop();
    cs_lo = 1'b0;
    i_mst.start();
    i_mst.wbits({TYPE_ID, 1'b0, 1'b1, 1'b1, 1'b0}, 8, ack);
    cmp1(ack, 1'b0);
    i_mst.stop();
  endtask
  task automatic t_writes();
    wr(8'h00, 8'h10, 8'h33, 1'b0, 1'b0);
    wr(8'h80, 8'h00, 8'h02, 1'b1, 1'b0);
    cmp1(write_enable_latch, 1'b1);
    wr(8'h7F, 8'hFF, 8'hA5, 1'b1, 1'b1);
    wr(8'h00, 8'h00, 8'h5A, 1'b1, 1'b1);
    sel(1'b0, ack);
    i_mst.wbits(8'h00, 8, ack);
    i_mst.wbits(8'h10, 8, ack);
    i_mst.wbits(8'h77, 4, ack);
    i_mst.stop();
    i_mst.tick(8);
    cmp1(busy, 1'b0);
  endtask
  task automatic t_random();
    sel(1'b0, ack);
    i_mst.wbits(8'h3F, 8, ack);
    i_mst.wbits(8'hFF, 8, ack);
    sel(1'b1, ack);
    cmp1(ack, 1'b1);
    i_mst.rbyte(1'b1, rd);
    cmp8(rd, 8'hA5);
    i_mst.rbyte(1'b0, rd);
    cmp8(rd, 8'h5A);
    i_mst.tick(16);
    cmp1(sda_oe, 1'b0);
    i_mst.rbyte(1'b0, rd);
    cmp8(rd, 8'hFF);
    i_mst.stop();
  endtask
  task automatic t_set_addr();
    sel(1'b0, ack);
    i_mst.wbits(8'h3F, 8, ack);
    i_mst.wbits(8'hFF, 8, ack);
    i_mst.stop();
    for (int i = 0; i < 2; i++)
    begin
      sel(1'b1, ack);
      i_mst.rbyte(1'b0, rd);
      cmp8(rd, i == 0 ? 8'hA5 : 8'h5A);
      i_mst.stop();
    end
  endtask
  task automatic t_lock();
    wr(8'h80, 8'h00, 8'h06, 1'b1, 1'b0);
    cmp1(register_write_latch, 1'b1);
    wr(8'h80, 8'h00, 8'h0B, 1'b1, 1'b1);
    cmp8({5'h00, lock}, 8'h03);
    cmp1(register_write_latch, 1'b0);
    wr(8'h00, 8'h20, 8'h11, 1'b0, 1'b0);
    wr(8'h80, 8'h00, 8'h02, 1'b1, 1'b0);
    wr(8'h80, 8'h00, 8'h06, 1'b1, 1'b0);
    wr(8'h80, 8'h00, 8'hEB, 1'b1, 1'b1);
    cmp1(protect_pin_enable, 1'b1);
    cmp8({6'h00, wd}, 8'h03);
    wp = 1'b1;
    wr(8'h80, 8'h00, 8'h02, 1'b0, 1'b0);
  endtask
  task automatic t_mid_reset();
    sel(1'b1, ack);
    i_mst.tick(2);
    reset_n_in = 1'b0;
    i_mst.tick(2);
    cmp1(sda_oe, 1'b0);
    cmp1(rst_act, 1'b1);
    reset_n_in = 1'b1;
    i_mst.stop();
    wait_clear();
    cmp8({5'h00, lock}, 8'h00);
  endtask
  initial
  begin
    i_mst.tick(2);
    reset_n_in = 1'b1;
    t_power_up();
    t_select();
    t_writes();
    t_random();
    t_set_addr();
    t_lock();
    t_mid_reset();
    summarize();
  end
endmodule // esr_top_tb
